// File: pmr_defs.svh
// Register offsets, field positions, reset values and timing counts of the port MAC rate block
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets inside one port page (low 12 address bits)
// ----------------------------------------------------------------
`define PMR_OFF_MAC_CTRL_A   12'h0400
`define PMR_OFF_MAC_CTRL_B   12'h0401
`define PMR_OFF_IRL_CTRL     12'h0403
`define PMR_OFF_PRIO_LIM0    12'h0410
`define PMR_OFF_PRIO_LIM7    12'h0417
`define PMR_OFF_STATUS       12'h0420
`define PMR_OFF_DROP_CNT     12'h0421

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMR_A_JUMBO          0
`define PMR_A_STORM          1
`define PMR_B_PASS_ALL       0
`define PMR_B_BP_EN          3
`define PMR_I_PRE            0
`define PMR_I_IFG            1
`define PMR_I_MODE_LO        2
`define PMR_I_RLFC           4
`define PMR_I_PPS            5
`define PMR_I_PORT_BASED     6

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PMR_RST_REG          8'h00
`define PMR_MASK_A           8'h0B
`define PMR_MASK_B           8'hBF
`define PMR_MASK_I           8'h7F
`define PMR_MASK_LIM         8'h7F

// ----------------------------------------------------------------
// Frame size figures in bytes
// ----------------------------------------------------------------
`define PMR_MAX_STD          14'd1500
`define PMR_MAX_JUMBO        14'd9000
`define PMR_MIN_PAYLOAD      14'd46
`define PMR_HDR_CRC_BYTES    17'd18
`define PMR_IFG_BYTES        17'd12
`define PMR_PRE_BYTES        17'd8

// ----------------------------------------------------------------
// Timing: times in ns, counts derived from the 8 ns clock
// ----------------------------------------------------------------
`define PMR_CLK_NS           8
`define PMR_REFILL_NS        8000
`define PMR_REFILL_CYC       (`PMR_REFILL_NS / `PMR_CLK_NS)
`define PMR_PPS_REFILL_NS    520833
`define PMR_PPS_REFILL_CYC   (`PMR_PPS_REFILL_NS / `PMR_CLK_NS)
`define PMR_FC_HOLD_NS       4000
`define PMR_FC_HOLD_CYC      (`PMR_FC_HOLD_NS / `PMR_CLK_NS)

`endif

// File: pmr_pkg.sv
// Types shared by the port MAC rate block
package pmr_pkg;

	// ----------------------------------------------------------------
	// Frame classes selected for counting and limiting
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PMR_LIM_ALL,
		PMR_LIM_BC_MC_FLOOD,
		PMR_LIM_BC_MC,
		PMR_LIM_BC
	} pmr_lmode_t;

endpackage : pmr_pkg

// File: pmr_port_mac.sv
// Port MAC control and ingress rate policing for ports 1 to 3, with its output FIFO
`timescale 1ns/100ps
`include "pmr_defs.svh"

// ----------------------------------------------------------------
// Descriptor FIFO
// ----------------------------------------------------------------
module pmr_fifo #(
	parameter int W = 20,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem_r [0:D-1];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;

	// Handshakes from the fill level
	assign in_ready  = (count_r != (AW+1)'(D));
	assign out_valid = (count_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rd_ptr_r];

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and level
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : pmr_fifo

// Functional notes
// - Storm protection bit set limits ingress broadcasts per interval; clear disables it.
// - Jumbo bit allows 9000 payload bytes, otherwise 1500 is the payload limit.
// - Back pressure, when enabled, acts only on half-duplex links, never full duplex.
// - Full-duplex links use PAUSE requests under the port flow control enable, not the back pressure bit.
// - CRC or length errors drop by default; pass-all forwards them mirror-only.
// - Pass-all never changes flow control frame filtering; switch-wide control does.
// - Scope bit set polices the whole port; clear polices each priority separately.
// - Packet mode bit counts packets; clear counts bits (bytes) of traffic.
// - Rate flow control bit asserts flow control on excess; clear never does.
// - Rate flow control acts only when the port's flow control is enabled.
// - Limit mode: 00 all, 01 bc/mc/flood, 10 bc/mc, 11 broadcast only.
// - IFG count bit adds 12 bytes per frame to the byte-mode rate charge.
// - Preamble count bit adds 8 bytes per frame to the rate charge.
// - Preamble count is ignored while packet mode is on.
// - Priority limits take effect only when the priority 7 limit is written.
module pmr_port_mac
	import pmr_pkg::*;
#(
	parameter int STORM_MAX      = 64,
	parameter int BURST_BYTES    = 65535,
	parameter int FIFO_DEPTH     = 16,
	parameter int PPS_REFILL_CYC = `PMR_PPS_REFILL_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	// Port link state, index 0 is port 1
	input  wire logic [2:0]  port_full_duplex,
	input  wire logic [2:0]  port_fc_en,
	input  wire logic        sw_fc_filter_en,
	// Ingress frame descriptors
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [1:0]  in_port,
	input  wire logic [2:0]  in_prio,
	input  wire logic [13:0] in_len,
	input  wire logic        in_bcast,
	input  wire logic        in_mcast,
	input  wire logic        in_flood,
	input  wire logic        in_pause,
	input  wire logic        in_crc_err,
	// Forwarded frame descriptors
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [1:0]       out_port,
	output logic [2:0]       out_prio,
	output logic [13:0]      out_len,
	output logic             out_mirror_only,
	// Flow control toward the link partners
	output logic [2:0]       pause_req,
	output logic [2:0]       back_pressure
);
	localparam int          NB       = 24;
	localparam int          CW       = 17;
	localparam int          FW       = 20;
	localparam logic [CW-1:0] BURST  = CW'(BURST_BYTES);
	localparam logic [9:0]  REFILL_N = 10'(`PMR_REFILL_CYC - 1);
	localparam logic [19:0] PPS_N    = 20'(PPS_REFILL_CYC - 1);
	localparam logic [8:0]  FC_HOLD  = 9'(`PMR_FC_HOLD_CYC);
	localparam logic [7:0]  STORM_LIM = 8'(STORM_MAX);

	// ----------------------------------------------------------------
	// Address decode helpers
	// ----------------------------------------------------------------

	// Port page index 0..2, or 3 when the upper nibble is not a port
	function automatic logic [1:0] page_of(input logic [15:0] a);
		page_of = (a[15:12] >= 4'h1 && a[15:12] <= 4'h3) ? 2'(a[15:12] - 4'h1) : 2'd3;
	endfunction : page_of

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_a_r   [0:2];
	logic [7:0]  ctrl_b_r   [0:2];
	logic [7:0]  irl_r      [0:2];
	logic [6:0]  lim_stage_r [0:NB-1];
	logic [6:0]  lim_act_r  [0:NB-1];
	logic [7:0]  drop_cnt_r [0:2];
	logic [CW-1:0] credit_r [0:NB-1];
	logic [7:0]  storm_cnt_r [0:2];
	logic [8:0]  fc_hold_r  [0:2];
	logic [9:0]  refill_cnt_r;
	logic [19:0] pps_cnt_r;
	logic        refill_tick;
	logic        pps_tick;
	logic [1:0]  wpage;
	logic [11:0] woff;

	assign wpage = page_of(reg_addr);
	assign woff  = reg_addr[11:0];

	// Control register writes, reserved read-only bits stay zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int p = 0; p < 3; p++) begin
				ctrl_a_r[p] <= `PMR_RST_REG;
				ctrl_b_r[p] <= `PMR_RST_REG;
				irl_r[p]    <= `PMR_RST_REG;
			end
		end else if (reg_wr && wpage != 2'd3) begin
			if (woff == `PMR_OFF_MAC_CTRL_A) begin
				ctrl_a_r[wpage] <= reg_wdata & `PMR_MASK_A;
			end
			if (woff == `PMR_OFF_MAC_CTRL_B) begin
				ctrl_b_r[wpage] <= reg_wdata & `PMR_MASK_B;
			end
			if (woff == `PMR_OFF_IRL_CTRL) begin
				irl_r[wpage] <= reg_wdata & `PMR_MASK_I;
			end
		end
	end

	// Priority limits: staged on write, committed by the priority 7 write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < NB; i++) begin
				lim_stage_r[i] <= '0;
				lim_act_r[i]   <= '0;
			end
		end else if (reg_wr && wpage != 2'd3) begin
			for (int i = 0; i < 8; i++) begin
				if (woff == `PMR_OFF_PRIO_LIM0 + 12'(i)) begin
					lim_stage_r[wpage*8+i] <= reg_wdata[6:0];
				end
			end
			if (woff == `PMR_OFF_PRIO_LIM7) begin
				for (int i = 0; i < 7; i++) begin
					lim_act_r[wpage*8+i] <= lim_stage_r[wpage*8+i];
				end
				lim_act_r[wpage*8+7] <= reg_wdata[6:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read, data valid in the following cycle only
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && wpage != 2'd3) begin
			reg_rdata <= 8'h00;
			if (woff == `PMR_OFF_MAC_CTRL_A) reg_rdata <= ctrl_a_r[wpage];
			if (woff == `PMR_OFF_MAC_CTRL_B) reg_rdata <= ctrl_b_r[wpage];
			if (woff == `PMR_OFF_IRL_CTRL) reg_rdata <= irl_r[wpage];
			for (int i = 0; i < 8; i++) begin
				if (woff == `PMR_OFF_PRIO_LIM0 + 12'(i)) begin
					reg_rdata <= {1'b0, lim_stage_r[wpage*8+i]};
				end
			end
			if (woff == `PMR_OFF_STATUS) begin
				reg_rdata <= {5'd0, back_pressure[wpage], pause_req[wpage],
					fc_hold_r[wpage] != 9'd0};
			end
			if (woff == `PMR_OFF_DROP_CNT) reg_rdata <= drop_cnt_r[wpage];
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Refill timers
	// ----------------------------------------------------------------
	assign refill_tick = (refill_cnt_r == REFILL_N);
	assign pps_tick    = (pps_cnt_r == PPS_N);

	// Byte and packet interval counters
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			refill_cnt_r <= '0;
			pps_cnt_r    <= '0;
		end else begin
			refill_cnt_r <= refill_tick ? '0 : refill_cnt_r + 1'b1;
			pps_cnt_r    <= pps_tick ? '0 : pps_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Frame classification and policing decision
	// ----------------------------------------------------------------
	logic          port_ok, jumbo, storm_en, pass_all, len_bad, bad, counted, pps_mode;
	logic          limited, fc_path, storm_hit, drop, take, fifo_in_valid;
	logic [1:0]    pi;
	pmr_lmode_t    lmode;
	logic [4:0]    bidx;
	logic [6:0]    code;
	logic [CW-1:0] charge;
	logic [FW-1:0] fifo_in_data, fifo_out_data;

	assign port_ok  = (in_port != 2'd0);
	assign pi       = port_ok ? in_port - 2'd1 : 2'd0;
	assign jumbo    = ctrl_a_r[pi][`PMR_A_JUMBO];
	assign storm_en = ctrl_a_r[pi][`PMR_A_STORM];
	assign pass_all = ctrl_b_r[pi][`PMR_B_PASS_ALL];
	assign lmode    = pmr_lmode_t'(irl_r[pi][`PMR_I_MODE_LO +: 2]);
	assign pps_mode = irl_r[pi][`PMR_I_PPS];

	// Payload size check against the selected ceiling
	assign len_bad = (in_len < `PMR_MIN_PAYLOAD) ||
		(in_len > (jumbo ? `PMR_MAX_JUMBO : `PMR_MAX_STD));
	assign bad     = in_crc_err | len_bad;

	// Frame classes counted against the limit
	always_comb begin
		case (lmode)
			PMR_LIM_ALL:         counted = 1'b1;
			PMR_LIM_BC_MC_FLOOD: counted = in_bcast | in_mcast | in_flood;
			PMR_LIM_BC_MC:       counted = in_bcast | in_mcast;
			PMR_LIM_BC:          counted = in_bcast;
			default:             counted = 1'b1;
		endcase
	end

	// Bucket: whole port uses slot 0, else one slot per priority
	assign bidx = 5'(pi) * 5'd8 +
		(irl_r[pi][`PMR_I_PORT_BASED] ? 5'd0 : 5'(in_prio));
	assign code = lim_act_r[bidx];

	// Charge: one packet, or bytes plus optional gap and preamble
	always_comb begin
		if (pps_mode) begin
			charge = CW'(1);
		end else begin
			charge = CW'(in_len) + `PMR_HDR_CRC_BYTES;
			if (irl_r[pi][`PMR_I_IFG]) charge = charge + `PMR_IFG_BYTES;
			if (irl_r[pi][`PMR_I_PRE]) charge = charge + `PMR_PRE_BYTES;
		end
	end

	assign limited   = (code != 7'd0) && counted && (credit_r[bidx] < charge);
	assign fc_path   = limited && irl_r[pi][`PMR_I_RLFC] && port_fc_en[pi];
	assign storm_hit = storm_en && in_bcast && (storm_cnt_r[pi] >= STORM_LIM);

	// Drop causes; flow control frames filtered only by the switch control
	assign drop = !port_ok
		|| (in_pause && sw_fc_filter_en)
		|| (bad && !pass_all)
		|| storm_hit
		|| (limited && !fc_path);

	assign take          = in_valid & in_ready;
	assign fifo_in_valid = in_valid & ~drop;
	assign fifo_in_data  = {in_port, in_prio, in_len, bad & pass_all};

	// ----------------------------------------------------------------
	// Credit buckets: refill by the committed code, charge per frame
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < NB; i++) begin
				credit_r[i] <= BURST;
			end
		end else begin
			for (int i = 0; i < NB; i++) begin
				logic [CW:0] c;
				logic        tick;
				c    = {1'b0, credit_r[i]};
				tick = irl_r[i/8][`PMR_I_PPS] ? pps_tick : refill_tick;
				if (tick) begin
					c = c + (CW+1)'(lim_act_r[i]);
					if (c > {1'b0, BURST}) c = {1'b0, BURST};
				end
				if (take && !drop && counted && code != 7'd0 && bidx == 5'(i)) begin
					c = (c > (CW+1)'(charge)) ? c - (CW+1)'(charge) : '0;
				end
				credit_r[i] <= c[CW-1:0];
			end
		end
	end

	// Broadcasts admitted per interval under storm protection
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int p = 0; p < 3; p++) storm_cnt_r[p] <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (refill_tick) begin
					storm_cnt_r[p] <= '0;
				end else if (take && !drop && in_bcast && pi == 2'(p) &&
					storm_cnt_r[p] != 8'hFF) begin
					storm_cnt_r[p] <= storm_cnt_r[p] + 8'd1;
				end
			end
		end
	end

	// Dropped frame counter per port, wraps
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int p = 0; p < 3; p++) drop_cnt_r[p] <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (take && drop && port_ok && pi == 2'(p)) begin
					drop_cnt_r[p] <= drop_cnt_r[p] + 8'd1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Flow control hold and its routing by duplex
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int p = 0; p < 3; p++) fc_hold_r[p] <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (take && fc_path && pi == 2'(p)) begin
					fc_hold_r[p] <= FC_HOLD;
				end else if (fc_hold_r[p] != 9'd0) begin
					fc_hold_r[p] <= fc_hold_r[p] - 9'd1;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_fc
			// PAUSE on full duplex, back pressure only on half duplex
			assign pause_req[g] = (fc_hold_r[g] != 9'd0) && port_full_duplex[g] &&
				port_fc_en[g];
			assign back_pressure[g] = (fc_hold_r[g] != 9'd0) && !port_full_duplex[g] &&
				ctrl_b_r[g][`PMR_B_BP_EN] && port_fc_en[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Output FIFO
	// ----------------------------------------------------------------
	pmr_fifo #(
		.W (FW),
		.D (FIFO_DEPTH)
	) pmr_fifo_inst (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (in_ready),
		.in_data   (fifo_in_data),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out_data)
	);

	assign {out_port, out_prio, out_len, out_mirror_only} = fifo_out_data;

endmodule : pmr_port_mac

// File: pmr_port_mac_asserts.sv
// Concurrent checks on the ports of the port MAC rate block
`timescale 1ns/100ps
module pmr_port_mac_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// Register and link state
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [2:0]  port_full_duplex,
	input wire logic [2:0]  port_fc_en,
	// Descriptor streams
	input wire logic        in_ready,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [1:0]  out_port,
	input wire logic [13:0] out_len,
	input wire logic        out_mirror_only,
	// Flow control
	input wire logic [2:0]  pause_req,
	input wire logic [2:0]  back_pressure
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_no_rd;
		!reg_rd;
	endsequence
	sequence s_stall;
		out_valid && !out_ready;
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_rd_idle;
		s_no_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	property p_rst;
		$rose(reset_n) |-> in_ready && !out_valid && pause_req == 3'h0 && back_pressure == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_bp_half;
		(back_pressure & port_full_duplex) == 3'h0;
	endproperty
	a_bp_half: assert property (p_bp_half) else $error("back pressure on full duplex");
	property p_pause_full;
		(pause_req & ~port_full_duplex) == 3'h0;
	endproperty
	a_pause_full: assert property (p_pause_full) else $error("pause on half duplex");
	property p_fc_en;
		((pause_req | back_pressure) & ~port_fc_en) == 3'h0;
	endproperty
	a_fc_en: assert property (p_fc_en) else $error("flow control while port disabled");
	property p_full;
		!in_ready |-> out_valid;
	endproperty
	a_full: assert property (p_full) else $error("input refused while buffer empty");
	property p_hold;
		s_stall |=> out_valid && $stable({out_port, out_len, out_mirror_only});
	endproperty
	a_hold: assert property (p_hold) else $error("descriptor changed while stalled");
	property p_port;
		out_valid |-> out_port != 2'h0;
	endproperty
	a_port: assert property (p_port) else $error("descriptor of port zero forwarded");
	property p_len;
		out_valid && !out_mirror_only |-> out_len >= 14'h002E && out_len <= 14'h2328;
	endproperty
	a_len: assert property (p_len) else $error("bad length forwarded");
endmodule : pmr_port_mac_asserts

bind pmr_port_mac pmr_port_mac_asserts pmr_port_mac_asserts_inst (
	.clk(clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_full_duplex(port_full_duplex), .port_fc_en(port_fc_en), .in_ready(in_ready),
	.out_valid(out_valid), .out_ready(out_ready), .out_port(out_port), .out_len(out_len),
	.out_mirror_only(out_mirror_only), .pause_req(pause_req), .back_pressure(back_pressure)
);

// File: pmr_link_sink.sv
// Far-side model taking forwarded descriptors, with a stall control
`timescale 1ns/100ps
module pmr_link_sink (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// Stall control
	input wire logic        stall,
	// Descriptor stream
	input wire logic        out_valid,
	output logic            out_ready,
	input wire logic        out_mirror_only,
	// Observations
	output logic [15:0]     got_cnt,
	output logic            got_mirror
);
	// Take descriptors unless stalled, count them
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_ready  <= 1'b0;
			got_cnt    <= 16'h0000;
			got_mirror <= 1'b0;
		end else begin
			out_ready <= !stall;
			if (out_valid && out_ready) begin
				got_cnt    <= got_cnt + 16'h0001;
				got_mirror <= out_mirror_only;
			end
		end
	end
endmodule : pmr_link_sink

// File: tb_pmr_port_mac.sv
// Self-checking bench of the port MAC rate block
`timescale 1ns/100ps
`include "pmr_defs.svh"
module tb_pmr_port_mac;
	logic        clk, reset_n, reg_wr, reg_rd, in_valid, in_bcast, in_mcast, in_flood;
	logic        in_pause, in_crc_err, sw_fc_filter_en, stall, in_ready, out_valid;
	logic        out_ready, out_mirror_only, got_mirror;
	logic [15:0] reg_addr, got_cnt, base;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [2:0]  port_full_duplex, port_fc_en, in_prio, out_prio, pause_req, back_pressure;
	logic [1:0]  in_port, out_port;
	logic [13:0] in_len, out_len;
	logic [4:0]  kind [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
	int          num_errors, tests_run, m, k;

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Design and far side
	pmr_port_mac #(.STORM_MAX(4), .BURST_BYTES(200), .FIFO_DEPTH(16), .PPS_REFILL_CYC(50))
	pmr_port_mac_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_full_duplex(port_full_duplex), .port_fc_en(port_fc_en),
		.sw_fc_filter_en(sw_fc_filter_en), .in_valid(in_valid), .in_ready(in_ready),
		.in_port(in_port), .in_prio(in_prio), .in_len(in_len), .in_bcast(in_bcast),
		.in_mcast(in_mcast), .in_flood(in_flood), .in_pause(in_pause),
		.in_crc_err(in_crc_err), .out_valid(out_valid), .out_ready(out_ready),
		.out_port(out_port), .out_prio(out_prio), .out_len(out_len),
		.out_mirror_only(out_mirror_only), .pause_req(pause_req),
		.back_pressure(back_pressure));
	pmr_link_sink pmr_link_sink_inst (.clk(clk), .reset_n(reset_n), .stall(stall),
		.out_valid(out_valid), .out_ready(out_ready), .out_mirror_only(out_mirror_only),
		.got_cnt(got_cnt), .got_mirror(got_mirror));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("Counts: %0d compared, %0d mismatched", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic timeout;
		num_errors++;
		$display("Wait limit reached at t=%0t", $time);
		report_and_stop();
	endtask : timeout
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask : rdc
	task automatic put(input logic [1:0] p, input logic [2:0] q, input logic [13:0] n,
		input logic [4:0] f);
		logic ok;
		int   i;
		@(posedge clk);
		in_port  <= p;
		in_prio  <= q;
		in_len   <= n;
		{in_bcast, in_mcast, in_flood, in_pause, in_crc_err} <= f;
		in_valid <= 1'b1;
		ok = 1'b0;
		for (i = 0; i < 40 && !ok; i++) begin
			@(negedge clk);
			ok = (in_ready === 1'b1);
			@(posedge clk);
		end
		in_valid <= 1'b0;
		if (!ok)
			timeout();
	endtask : put
	task automatic settle;
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (out_valid !== 1'b0 && i < 60);
		if (i >= 60)
			timeout();
	endtask : settle
	// Send frames, then compare how many reached the far side
	task automatic burst(input logic [1:0] p, input logic [2:0] q, input logic [13:0] n,
		input logic [4:0] f, input int c, input logic [15:0] e);
		base = got_cnt;
		repeat (c) put(p, q, n, f);
		settle();
		chk(got_cnt - base, e);
	endtask : burst

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, reg_wr, reg_rd, in_valid, in_bcast, in_mcast, in_flood} = 7'h00;
		{in_pause, in_crc_err, sw_fc_filter_en, stall} = 4'h0;
		{reg_addr, reg_wdata, in_prio, in_port, in_len} = 43'h0;
		port_full_duplex = 3'h7;
		port_fc_en = 3'h0;
		num_errors = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		// Reset values, writable bits, unmapped places
		rdc(16'h1400, 8'h00);
		rdc(16'h1403, 8'h00);
		wr(16'h2400, 8'hFF);
		rdc(16'h2400, 8'h0B);
		wr(16'h2401, 8'hFF);
		rdc(16'h2401, 8'hBF);
		wr(16'h2403, 8'hFF);
		rdc(16'h2403, 8'h7F);
		wr(16'h2402, 8'hFF);
		rdc(16'h2402, 8'h00);
		rdc(16'h0400, 8'h00);
		wr(16'h2400, 8'h00);
		wr(16'h2401, 8'h00);
		$display("done: registers");
		// Payload limits, standard and jumbo
		burst(2'h1, 3'h0, `PMR_MAX_STD, 5'h00, 1, 16'h0001);
		burst(2'h1, 3'h0, `PMR_MAX_STD + 14'h0001, 5'h00, 1, 16'h0000);
		burst(2'h1, 3'h0, `PMR_MIN_PAYLOAD - 14'h0001, 5'h00, 1, 16'h0000);
		wr(16'h1400, 8'h01);
		burst(2'h1, 3'h0, `PMR_MAX_JUMBO, 5'h00, 1, 16'h0001);
		burst(2'h1, 3'h0, `PMR_MAX_JUMBO + 14'h0001, 5'h00, 1, 16'h0000);
		wr(16'h1400, 8'h00);
		$display("done: length");
		// Bad frames to mirror, pause filtering apart
		burst(2'h1, 3'h0, 14'h002E, 5'h01, 1, 16'h0000);
		wr(16'h1401, 8'h01);
		burst(2'h1, 3'h0, 14'h002E, 5'h01, 1, 16'h0001);
		chk({15'h0000, got_mirror}, 16'h0001);
		burst(2'h1, 3'h0, 14'h002E, 5'h00, 1, 16'h0001);
		chk({15'h0000, got_mirror}, 16'h0000);
		@(posedge clk);
		sw_fc_filter_en <= 1'b1;
		burst(2'h1, 3'h0, 14'h002E, 5'h02, 1, 16'h0000);
		@(posedge clk);
		sw_fc_filter_en <= 1'b0;
		burst(2'h1, 3'h0, 14'h002E, 5'h02, 1, 16'h0001);
		wr(16'h1401, 8'h00);
		$display("done: pass all");
		// Broadcast storm protection on and off
		wr(16'h1400, 8'h02);
		burst(2'h1, 3'h0, 14'h002E, 5'h10, 6, 16'h0004);
		wr(16'h1400, 8'h00);
		burst(2'h1, 3'h0, 14'h002E, 5'h10, 6, 16'h0006);
		$display("done: storm");
		// Staged limits, byte and packet charges
		wr(16'h1410, 8'h01);
		burst(2'h1, 3'h0, 14'h002E, 5'h00, 4, 16'h0004);
		for (k = 1; k < 5; k++)
			wr(16'h1410 + 16'(k), 8'h01);
		wr(16'h1417, 8'h01);
		burst(2'h1, 3'h1, 14'h002E, 5'h00, 4, 16'h0003);
		wr(16'h1403, 8'h02);
		burst(2'h1, 3'h2, 14'h002E, 5'h00, 4, 16'h0002);
		wr(16'h1403, 8'h01);
		burst(2'h1, 3'h3, 14'h002E, 5'h00, 4, 16'h0002);
		wr(16'h1403, 8'h21);
		burst(2'h1, 3'h4, `PMR_MAX_STD, 5'h00, 4, 16'h0004);
		rdc(16'h1421, 8'h0C);
		$display("done: rate charge");
		// Frame classes, port and priority scope
		wr(16'h2410, 8'h01);
		wr(16'h2417, 8'h00);
		for (m = 0; m < 4; m++) begin
			wr(16'h2403, {4'h4, 2'(m), 2'b00});
			for (k = 0; k < 4; k++)
				burst(2'h2, 3'h5, `PMR_MAX_STD, kind[k], 1, 16'(k < m));
		end
		wr(16'h2403, 8'h00);
		burst(2'h2, 3'h5, `PMR_MAX_STD, 5'h10, 1, 16'h0001);
		$display("done: limit mode");
		// Flow control on excess
		wr(16'h3410, 8'h01);
		wr(16'h3417, 8'h00);
		wr(16'h3403, 8'h50);
		burst(2'h3, 3'h0, `PMR_MAX_STD, 5'h00, 1, 16'h0000);
		chk({13'h0000, pause_req}, 16'h0000);
		@(posedge clk);
		port_fc_en <= 3'h4;
		burst(2'h3, 3'h0, `PMR_MAX_STD, 5'h00, 1, 16'h0001);
		chk({13'h0000, pause_req}, 16'h0004);
		chk({13'h0000, back_pressure}, 16'h0000);
		@(posedge clk);
		port_full_duplex <= 3'h3;
		@(negedge clk);
		chk({10'h000, pause_req, back_pressure}, 16'h0000);
		wr(16'h3401, 8'h08);
		@(negedge clk);
		chk({13'h0000, back_pressure}, 16'h0004);
		rdc(16'h3420, 8'h05);
		wr(16'h3403, 8'h40);
		burst(2'h3, 3'h0, `PMR_MAX_STD, 5'h00, 1, 16'h0000);
		$display("done: flow control");
		// Buffer fills while the far side stalls
		@(posedge clk);
		stall <= 1'b1;
		base = got_cnt;
		repeat (16) put(2'h2, 3'h6, 14'h002E, 5'h00);
		@(negedge clk);
		chk({15'h0000, in_ready}, 16'h0000);
		chk({out_prio, out_len[12:0]}, 16'hC02E);
		@(posedge clk);
		stall <= 1'b0;
		settle();
		chk(got_cnt - base, 16'h0010);
		$display("done: buffer");
		report_and_stop();
	end
endmodule : tb_pmr_port_mac
